// *** rtl/fpc_flash_ctrl.sv ***
`timescale 1ns/1ps
// What this block does
// - write 5 then A to launch
// - map bit sends data writes to latches
// - busy set during programming, cleared after
// - software cannot write the busy flag
// - control register resets to zero
// - array of 128-byte pages, 128/256 pages
// - user and extra row launches self-erase before programming
// - erase and program take 10 ms
// - flash byte reads have no wait states
// - boot bit set starts at 0000h
// - boot bit clear starts at F400h
// - security bit 7 selects core timing
// - security bits 2-0 lock, bit 3 reserved
// - mode picks space, reserved launch ignored
// - address bits select byte and page
// - cpu idles until programming completes
// - only loaded latch bytes get programmed
module fpc_flash_ctrl
    import fpc_pkg::*;
#(
    parameter int PAGES      = FPC_PAGES,
    parameter int PROG_CYCLES = FPC_PROG_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        xdata_wr,
    input  wire logic [15:0] xdata_addr,
    input  wire logic [7:0]  xdata_wdata,
    output logic             xdata_to_latch,
    input  wire logic        code_rd,
    input  wire logic [15:0] code_addr,
    output logic      [7:0]  code_rdata,
    output logic             cpu_idle_req,
    output logic      [15:0] boot_addr,
    output logic             double_speed_select,
    output logic      [2:0]  lock_level_bits,
    output logic      [1:0]  osc_power_control
);
    localparam int ARR_BYTES = PAGES * FPC_PAGE_BYTES;
    localparam int ARR_W     = $clog2(ARR_BYTES);
    localparam int CNT_W     = $clog2(PROG_CYCLES + 1);

    typedef enum logic [1:0] {FPC_IDLE, FPC_ERASE, FPC_PROG, FPC_WAIT} fpc_state_t;

    fpc_latch_if lat ();
    fpc_column_latch #(.DEPTH(FPC_PAGE_BYTES)) u_latch (.clk(clk), .rst_n(rst_n), .lat(lat.store));

    logic [7:0]            array_r [ARR_BYTES];
    logic [7:0]            extra_row_space_r [FPC_PAGE_BYTES];
    logic [7:0]            sec_r;
    logic [3:0]            nib_r;
    logic                  map_r;
    logic [1:0]            space_r;
    logic                  busy_r;
    logic                  armed_r;
    logic [1:0]            prog_space_r;
    logic [FPC_PAGE_W-1:0] page_r;
    fpc_state_t            state_r;
    logic [FPC_OFS_W:0]    walk_r;
    logic [CNT_W-1:0]      cnt_r;
    logic                  ctrl_wr;
    logic                  launch;
    logic                  latch_wr;
    logic [ARR_W-1:0]      tgt;

    assign ctrl_wr  = sfr_wr && sfr_addr == FPC_CTRL_ADDR;
    assign latch_wr = xdata_wr && map_r;
    // only an A directly after a 5, with a defined space, while idle
    assign launch   = ctrl_wr && !busy_r && armed_r && sfr_wdata[7:4] == FPC_NIB_LAUNCH
                      && sfr_wdata[FPC_MODE_LSB +: 2] != 2'h3;

    // control register fields; busy bit is never taken from the bus
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            nib_r   <= FPC_CTRL_RESET[7:4];
            map_r   <= FPC_CTRL_RESET[FPC_MAP_BIT];
            space_r <= FPC_CTRL_RESET[2:1];
        end
        else if (ctrl_wr)
        begin
            nib_r   <= sfr_wdata[7:4];
            map_r   <= sfr_wdata[FPC_MAP_BIT];
            space_r <= sfr_wdata[FPC_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            armed_r <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            armed_r <= sfr_wdata[7:4] == FPC_NIB_UNLOCK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            page_r <= '0;
        end
        else if (latch_wr)
        begin
            page_r <= xdata_addr[14:7];
        end
    end

    assign lat.wr    = latch_wr;
    assign lat.wofs  = xdata_addr[FPC_OFS_W-1:0];
    assign lat.wdata = xdata_wdata;
    assign lat.clear = state_r == FPC_WAIT && cnt_r == '0;
    assign lat.rofs  = walk_r[FPC_OFS_W-1:0];
    assign tgt       = ARR_W'({page_r, walk_r[FPC_OFS_W-1:0]});

    // sequencer: erase pass, program pass, then hold out the full time
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r      <= FPC_IDLE;
            busy_r       <= 1'b0;
            walk_r       <= '0;
            cnt_r        <= '0;
            prog_space_r <= FPC_SPACE_USER;
        end
        else
        begin
            case (state_r)
                FPC_IDLE:
                begin
                    // the space travels with the launching write, not the unlock write
                    if (launch)
                    begin
                        busy_r       <= 1'b1;
                        prog_space_r <= sfr_wdata[FPC_MODE_LSB +: 2];
                        walk_r       <= '0;
                        cnt_r        <= CNT_W'(PROG_CYCLES - 1);
                        state_r      <= FPC_ERASE;
                    end
                end
                FPC_ERASE, FPC_PROG:
                begin
                    cnt_r  <= cnt_r - 1'b1;
                    walk_r <= walk_r + 1'b1;
                    if (walk_r == FPC_OFS_W'(FPC_PAGE_BYTES - 1))
                    begin
                        walk_r  <= '0;
                        state_r <= state_r == FPC_ERASE ? FPC_PROG : FPC_WAIT;
                    end
                end
                FPC_WAIT:
                begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r == '0)
                    begin
                        busy_r  <= 1'b0;
                        state_r <= FPC_IDLE;
                    end
                end
                default:
                begin
                    state_r <= FPC_IDLE;
                end
            endcase
        end
    end

    // flash array storage; erased value is all ones
    always_ff @(posedge clk)
    begin
        if ((state_r == FPC_ERASE || state_r == FPC_PROG) && lat.rloaded)
        begin
            if (prog_space_r == FPC_SPACE_USER)
            begin
                array_r[tgt] <= state_r == FPC_ERASE ? 8'hff : lat.rdata;
            end
            else if (prog_space_r == FPC_SPACE_EXTRA_ROW_SPACE)
            begin
                extra_row_space_r[walk_r[FPC_OFS_W-1:0]] <= state_r == FPC_ERASE ? 8'hff : lat.rdata;
            end
        end
    end

    // security byte: software reaches only the upper four bits
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sec_r <= FPC_SEC_DEFAULT;
        end
        else if (state_r == FPC_PROG && prog_space_r == FPC_SPACE_SECURITY && walk_r == '0 && lat.rloaded)
        begin
            sec_r <= (lat.rdata & FPC_SEC_SW_MASK) | (sec_r & ~FPC_SEC_SW_MASK);
        end
    end

    // bus-facing registered outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sfr_rdata      <= '0;
            code_rdata     <= '0;
            xdata_to_latch <= 1'b0;
            cpu_idle_req   <= 1'b0;
        end
        else
        begin
            xdata_to_latch <= map_r;
            cpu_idle_req   <= launch || (busy_r && !(state_r == FPC_WAIT && cnt_r == '0));
            if (sfr_rd && sfr_addr == FPC_CTRL_ADDR)
            begin
                sfr_rdata <= {nib_r, map_r, space_r, busy_r};
            end
            else
            begin
                sfr_rdata <= '0;
            end
            // single-cycle read, data in the cycle after the request
            if (code_rd)
            begin
                case (space_r)
                    FPC_SPACE_USER:     code_rdata <= array_r[code_addr[ARR_W-1:0]];
                    FPC_SPACE_EXTRA_ROW_SPACE:     code_rdata <= extra_row_space_r[code_addr[FPC_OFS_W-1:0]];
                    FPC_SPACE_SECURITY: code_rdata <= {sec_r[7:4], 1'b0, sec_r[2:0]};
                    default:            code_rdata <= 8'hff;
                endcase
            end
        end
    end

    // boot straps, taken from the security byte
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            boot_addr           <= FPC_BOOT_LOADER;
            double_speed_select <= 1'b0;
            lock_level_bits     <= '0;
            osc_power_control   <= '0;
        end
        else
        begin
            boot_addr           <= sec_r[FPC_SEC_BOOT_BIT] ? FPC_BOOT_USER : FPC_BOOT_LOADER;
            double_speed_select <= !sec_r[FPC_SEC_SPEED_BIT];
            lock_level_bits     <= sec_r[FPC_SEC_LOCK_LSB +: 3];
            osc_power_control   <= sec_r[FPC_SEC_OSC_LSB +: 2];
        end
    end
endmodule : fpc_flash_ctrl

// *** rtl/fpc_pkg.sv ***
package fpc_pkg;
    // special function register address of the control register
    localparam logic [7:0] FPC_CTRL_ADDR        = 8'hd1;
    localparam logic [7:0] FPC_CTRL_RESET       = 8'h00;
    // control register field positions
    localparam int         FPC_BUSY_BIT         = 0;
    localparam int         FPC_MODE_LSB         = 1;
    localparam int         FPC_MAP_BIT          = 3;
    localparam int         FPC_NIB_LSB          = 4;
    localparam logic [3:0] FPC_NIB_UNLOCK       = 4'h5;
    localparam logic [3:0] FPC_NIB_LAUNCH       = 4'ha;
    // space select encodings
    localparam logic [1:0] FPC_SPACE_USER       = 2'h0;
    localparam logic [1:0] FPC_SPACE_EXTRA_ROW_SPACE       = 2'h1;
    localparam logic [1:0] FPC_SPACE_SECURITY   = 2'h2;
    // array geometry
    localparam int         FPC_PAGE_BYTES       = 128;
    localparam int         FPC_PAGES            = 256;
    localparam int         FPC_OFS_W            = 7;
    localparam int         FPC_PAGE_W           = 8;
    // security byte fields; default: bootloader boot, standard timing, level four
    localparam int         FPC_SEC_SPEED_BIT    = 7;
    localparam int         FPC_SEC_BOOT_BIT     = 6;
    localparam int         FPC_SEC_OSC_LSB      = 4;
    localparam int         FPC_SEC_LOCK_LSB     = 0;
    localparam logic [7:0] FPC_SEC_DEFAULT      = 8'hb0;
    localparam logic [7:0] FPC_SEC_SW_MASK      = 8'hf0;
    localparam logic [15:0] FPC_BOOT_USER       = 16'h0000;
    localparam logic [15:0] FPC_BOOT_LOADER     = 16'hf400;
    // timing
    localparam int         FPC_CLK_HZ           = 25000000;
    localparam int         FPC_PROG_TIME_MS     = 10;
    localparam int         FPC_PROG_CYCLES      = FPC_CLK_HZ / 1000 * FPC_PROG_TIME_MS;
endpackage : fpc_pkg

// *** rtl/fpc_latch_if.sv ***
`timescale 1ns/1ps
interface fpc_latch_if;
    import fpc_pkg::*;
    logic                  wr;
    logic [FPC_OFS_W-1:0]  wofs;
    logic [7:0]            wdata;
    logic                  clear;
    logic [FPC_OFS_W-1:0]  rofs;
    logic [7:0]            rdata;
    logic                  rloaded;
    modport ctrl  (output wr, output wofs, output wdata, output clear, output rofs, input rdata, input rloaded);
    modport store (input wr, input wofs, input wdata, input clear, input rofs, output rdata, output rloaded);
endinterface : fpc_latch_if

// *** rtl/fpc_column_latch.sv ***
`timescale 1ns/1ps
module fpc_column_latch
    import fpc_pkg::*;
#(
    parameter int DEPTH = FPC_PAGE_BYTES
)
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    fpc_latch_if.store lat
);
    logic [7:0]       mem_r [DEPTH];
    logic [DEPTH-1:0] loaded_r;

    always_ff @(posedge clk)
    begin
        if (lat.wr)
        begin
            mem_r[lat.wofs] <= lat.wdata;
        end
    end

    // per-byte loaded marks, so only written bytes get erased and programmed
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_mark
            always_ff @(posedge clk)
            begin
                if (!rst_n || lat.clear)
                begin
                    loaded_r[g] <= 1'b0;
                end
                else if (lat.wr && lat.wofs == FPC_OFS_W'(g))
                begin
                    loaded_r[g] <= 1'b1;
                end
            end
        end
    endgenerate

    assign lat.rdata   = mem_r[lat.rofs];
    assign lat.rloaded = loaded_r[lat.rofs];
endmodule : fpc_column_latch

// *** tb/fpc_flash_ctrl_monitor.sv ***
`timescale 1ns/1ps
module fpc_flash_ctrl_monitor
    import fpc_pkg::*;
#(
    parameter int PAGES       = FPC_PAGES,
    parameter int PROG_CYCLES = FPC_PROG_CYCLES
)
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        xdata_to_latch,
    input wire logic        cpu_idle_req,
    input wire logic [15:0] boot_addr,
    input wire logic        double_speed_select
);
    localparam int LO = PROG_CYCLES - 3;
    localparam int HI = PROG_CYCLES + 1;
    logic        ctl_wr;
    logic        launch;
    logic        unlock_r;
    logic [31:0] cnt_r;
    assign ctl_wr = sfr_wr && sfr_addr == FPC_CTRL_ADDR;
    assign launch = ctl_wr && unlock_r && !cpu_idle_req && sfr_wdata[7:4] == FPC_NIB_LAUNCH
                    && sfr_wdata[2:1] != 2'h3;
    // unlock only tracked from idle state; writes made while busy are left unjudged
    always_ff @(posedge clk)
        if (!rst_n)
            unlock_r <= 1'b0;
        else if (ctl_wr)
            unlock_r <= !cpu_idle_req && sfr_wdata[7:4] == FPC_NIB_UNLOCK;
    always_ff @(posedge clk)
        if (!rst_n || !cpu_idle_req)
            cnt_r <= 32'h0;
        else
            cnt_r <= cnt_r + 32'h1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_launch; launch |=> cpu_idle_req; endproperty
    a_launch: assert property (p_launch) else $error("launch did not start programming");
    property p_refuse; ctl_wr && !launch && !cpu_idle_req |=> !cpu_idle_req; endproperty
    a_refuse: assert property (p_refuse) else $error("busy without valid launch");
    property p_len; $fell(cpu_idle_req) |-> cnt_r >= LO && cnt_r <= HI; endproperty
    a_len: assert property (p_len) else $error("programming time wrong");
    property p_hold; $rose(cpu_idle_req) |-> cpu_idle_req [*8]; endproperty
    a_hold: assert property (p_hold) else $error("idle request dropped early");
    property p_status;
        $past(sfr_rd) && $past(sfr_addr) == FPC_CTRL_ADDR |-> sfr_rdata[0] == $past(cpu_idle_req);
    endproperty
    a_status: assert property (p_status) else $error("busy flag read wrong");
    property p_map;
        ctl_wr && !cpu_idle_req ##1 !ctl_wr |=> xdata_to_latch == $past(sfr_wdata[FPC_MAP_BIT], 2);
    endproperty
    a_map: assert property (p_map) else $error("latch mapping wrong");
    property p_cfg;
        $past(rst_n) && $past(rst_n, 2) && !cpu_idle_req && !$past(cpu_idle_req) && !$past(cpu_idle_req, 2)
        |-> $stable({boot_addr, double_speed_select});
    endproperty
    a_cfg: assert property (p_cfg) else $error("config changed without programming");
    property p_boot; boot_addr == FPC_BOOT_USER || boot_addr == FPC_BOOT_LOADER; endproperty
    a_boot: assert property (p_boot) else $error("boot address illegal");
    property p_reset; $rose(rst_n) |-> sfr_rdata == 8'h00 && !cpu_idle_req && !xdata_to_latch; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    c_launch: cover property (launch);
    c_done: cover property ($fell(cpu_idle_req));
    c_fast: cover property (double_speed_select);
endmodule : fpc_flash_ctrl_monitor
bind fpc_flash_ctrl fpc_flash_ctrl_monitor #(.PAGES(PAGES), .PROG_CYCLES(PROG_CYCLES)) i_mon (
    .clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xdata_to_latch(xdata_to_latch),
    .cpu_idle_req(cpu_idle_req), .boot_addr(boot_addr), .double_speed_select(double_speed_select));

// *** tb/fpc_cpu_model.sv ***
`timescale 1ns/1ps
module fpc_cpu_model
    import fpc_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   cpu_idle_req,
    output logic        sfr_wr,
    output logic        sfr_rd,
    output logic [7:0]  sfr_addr,
    output logic [7:0]  sfr_wdata,
    output logic        xdata_wr,
    output logic [15:0] xdata_addr,
    output logic [7:0]  xdata_wdata,
    output logic        code_rd,
    output logic [15:0] code_addr
);
    initial
    begin
        {sfr_wr, sfr_rd, xdata_wr, code_rd} = 4'h0;
        {sfr_addr, sfr_wdata, xdata_wdata} = 24'h0;
        {xdata_addr, code_addr} = 32'h0;
    end
    // released buses show inverted data so stale values never look valid
    task automatic sfr_acc(input logic [7:0] a, input logic [7:0] d, input logic rd);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = !rd;
        sfr_rd = rd;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask : sfr_acc
    task automatic sfr_write(input logic [7:0] d);
        sfr_acc(FPC_CTRL_ADDR, d, 1'b0);
    endtask : sfr_write
    task automatic sfr_read;
        sfr_acc(FPC_CTRL_ADDR, 8'h00, 1'b1);
    endtask : sfr_read
    task automatic xwrite(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        xdata_addr = a;
        xdata_wdata = d;
        xdata_wr = 1'b1;
        @(negedge clk);
        xdata_wr = 1'b0;
        xdata_wdata = ~d;
    endtask : xwrite
    // no fetch is possible while programming, so the core stalls first
    task automatic code_read(input logic [15:0] a, output logic stall);
        for (int i = 0; i < 2000 && cpu_idle_req !== 1'b0; i++)
            @(negedge clk);
        stall = cpu_idle_req !== 1'b0;
        @(negedge clk);
        code_addr = a;
        code_rd = 1'b1;
        @(negedge clk);
        code_rd = 1'b0;
        code_addr = ~a;
    endtask : code_read
endmodule : fpc_cpu_model

// *** tb/fpc_flash_ctrl_tb.sv ***
`timescale 1ns/1ps
module fpc_flash_ctrl_tb;
    import fpc_pkg::*;
    localparam int PC = 300;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sfr_wr, sfr_rd, xdata_wr, code_rd, xdata_to_latch, cpu_idle_req, double_speed_select;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, code_rdata, sec;
    logic [15:0] xdata_addr, code_addr, boot_addr;
    logic [2:0]  lock_level_bits;
    logic [1:0]  osc_power_control;
    logic [7:0]  exp_mem [FPC_PAGE_BYTES];
    logic [7:0]  page;
    logic [6:0]  ofs;
    logic [7:0]  fa;
    logic        stall;
    int          seed = 16;
    int          bad_count = 0;
    int          cmp_count = 0;
    always #20 clk = ~clk;
    fpc_flash_ctrl #(.PROG_CYCLES(PC)) i_dut (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr),
        .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata), .xdata_to_latch(xdata_to_latch),
        .code_rd(code_rd), .code_addr(code_addr), .code_rdata(code_rdata), .cpu_idle_req(cpu_idle_req),
        .boot_addr(boot_addr), .double_speed_select(double_speed_select),
        .lock_level_bits(lock_level_bits), .osc_power_control(osc_power_control));
    fpc_cpu_model i_cpu (.clk(clk), .cpu_idle_req(cpu_idle_req), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
        .xdata_wdata(xdata_wdata), .code_rd(code_rd), .code_addr(code_addr));
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // retry fires a second unlock pair while busy, which must be ignored
    task automatic launch(input logic [3:0] low, input logic retry);
        int n;
        i_cpu.sfr_write({FPC_NIB_UNLOCK, low});
        i_cpu.sfr_write({FPC_NIB_LAUNCH, low});
        i_cpu.sfr_read();
        check(16'(sfr_rdata[0]), 16'h0001);
        check(16'(cpu_idle_req), 16'h0001);
        n = 2;
        if (retry)
        begin
            i_cpu.sfr_write({FPC_NIB_UNLOCK, low});
            i_cpu.sfr_write({FPC_NIB_LAUNCH, low});
            n = 6;
        end
        while (cpu_idle_req !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check(16'(n >= PC - 2 && n <= PC + 2), 16'h0001);
        if (n >= 2000)
            wrap_up();
        repeat (4) @(negedge clk);
        check(16'(cpu_idle_req), 16'h0000);
    endtask : launch
    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        i_cpu.sfr_read();
        check(16'(sfr_rdata), 16'(FPC_CTRL_RESET));
        check(boot_addr, FPC_BOOT_LOADER);
        check(16'(double_speed_select), 16'h0000);
        i_cpu.sfr_write(8'ha1);
        i_cpu.sfr_read();
        check(16'(sfr_rdata[3:0]), 16'h0000);
        i_cpu.sfr_write(8'h56);
        i_cpu.sfr_write(8'ha6);
        i_cpu.sfr_read();
        check(16'(sfr_rdata[3:0]), 16'h0006);
        // other register addresses must neither alter nor read back the control register
        fa = 8'($random(seed));
        if (fa == FPC_CTRL_ADDR)
            fa = ~fa;
        i_cpu.sfr_acc(fa, 8'($random(seed)), 1'b0);
        i_cpu.sfr_read();
        check(16'(sfr_rdata), 16'({FPC_NIB_LAUNCH, 4'h6}));
        i_cpu.sfr_acc(fa, 8'h00, 1'b1);
        check(16'(sfr_rdata), 16'h0000);
        page = 8'($random(seed));
        i_cpu.sfr_write(8'h08);
        // the steering output is registered once more after the map bit
        @(negedge clk);
        check(16'(xdata_to_latch), 16'h0001);
        for (int i = 0; i < FPC_PAGE_BYTES; i++)
        begin
            exp_mem[i] = 8'($random(seed));
            i_cpu.xwrite({1'b0, page, 7'(i)}, exp_mem[i]);
        end
        launch(4'h8, 1'b0);
        i_cpu.sfr_write(8'h00);
        i_cpu.xwrite({1'b0, page, 7'd10}, ~exp_mem[10]);
        i_cpu.sfr_write(8'h08);
        for (int k = 0; k < 6; k++)
        begin
            ofs = (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($random(seed));
            exp_mem[ofs] = 8'($random(seed));
            i_cpu.xwrite({1'b0, page, ofs}, exp_mem[ofs]);
        end
        launch(4'h8, 1'b1);
        i_cpu.sfr_write(8'h00);
        for (int i = 0; i < FPC_PAGE_BYTES; i++)
        begin
            i_cpu.code_read({1'b0, page, 7'(i)}, stall);
            check(16'(stall), 16'h0000);
            check(16'(code_rdata), 16'(exp_mem[i]));
        end
        // extra row is picked by the mode bits alone; the page bits of the address are ignored
        i_cpu.sfr_write(8'h0a);
        for (int i = 0; i < FPC_PAGE_BYTES; i++)
        begin
            exp_mem[i] = 8'($random(seed));
            i_cpu.xwrite({9'h1ff, 7'(i)}, exp_mem[i]);
        end
        launch(4'ha, 1'b0);
        i_cpu.sfr_write(8'h02);
        for (int i = 0; i < FPC_PAGE_BYTES; i++)
        begin
            i_cpu.code_read({9'h1ff, 7'(i)}, stall);
            check(16'(code_rdata), 16'(exp_mem[i]));
        end
        i_cpu.sfr_write(8'h06);
        i_cpu.code_read(16'h0000, stall);
        check(16'(code_rdata), 16'h00ff);
        sec = {2'b01, 6'($random(seed))};
        i_cpu.sfr_write(8'h0c);
        i_cpu.xwrite(16'h0000, sec);
        launch(4'hc, 1'b0);
        i_cpu.sfr_write(8'h04);
        i_cpu.code_read(16'h0000, stall);
        check(16'(code_rdata), 16'({sec[7:4], 1'b0, FPC_SEC_DEFAULT[2:0]}));
        check(boot_addr, sec[6] ? FPC_BOOT_USER : FPC_BOOT_LOADER);
        check(16'(double_speed_select), 16'(!sec[7]));
        check(16'({lock_level_bits, osc_power_control}), 16'({FPC_SEC_DEFAULT[2:0], sec[5:4]}));
        // a second reset in mid-run brings back the control register and the boot strap
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        i_cpu.sfr_read();
        check(16'(sfr_rdata), 16'(FPC_CTRL_RESET));
        check(boot_addr, FPC_BOOT_LOADER);
        wrap_up();
    end
endmodule : fpc_flash_ctrl_tb
